//--- cpm_pin_mux.sv
`timescale 1ns/1ns
`include "cpm_map.svh"

module cpm_pin_mux (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic i_mclk_pin,
	input wire logic i_bclk_pin,
	output logic o_bclk_pin,
	output logic o_bclk_pin_oe,
	input wire logic i_wclk_pin,
	output logic o_wclk_pin,
	output logic o_wclk_pin_oe,
	input wire logic i_data_in_pin,
	output logic o_data_out_pin,
	output logic o_data_out_pin_oe,
	input wire logic i_secondary_clock_in_pin,
	output logic o_secondary_data_out_pin,
	output logic o_secondary_data_out_pin_oe,
	input wire logic i_general_io_pin,
	output logic o_general_io_pin,
	output logic o_general_io_pin_oe,
	input wire logic i_bclk_core,
	input wire logic i_wclk_core,
	input wire logic i_serial_dout,
	input wire logic i_aux_clk,
	input wire logic i_first_interrupt_out,
	input wire logic i_second_interrupt_out,
	input wire logic i_adc_wclk,
	input wire logic i_sec_bclk_out,
	input wire logic i_sec_wclk_out,
	input wire logic i_sec_dout,
	input wire logic i_digital_mic_clock,
	output logic o_pll_ref,
	output logic o_codec_clk,
	output logic o_bclk_in,
	output logic o_wclk_in,
	output logic o_serial_din,
	output logic o_sec_bclk_in,
	output logic o_sec_wclk_in,
	output logic o_adc_wclk_in,
	output logic o_sec_din,
	output logic o_digital_mic_data,
	output logic o_headset_detect,
	output logic [7:0] o_analog_power
);

	cpm_pkg::cpm_byte_t clk_source_select;
	cpm_pkg::cpm_byte_t serial_clock_direction;
	cpm_pkg::cpm_byte_t secondary_interface_routing;
	cpm_pkg::cpm_byte_t gpio_pin_function;
	cpm_pkg::cpm_byte_t data_out_pin_function;
	cpm_pkg::cpm_byte_t data_in_pin_function;
	cpm_pkg::cpm_byte_t secondary_out_pin_function;
	cpm_pkg::cpm_byte_t secondary_in_pin_function;
	cpm_pkg::cpm_byte_t headset_detect_control;
	cpm_pkg::cpm_byte_t mic_input_select;
	cpm_pkg::cpm_byte_t analog_power_enable;

	logic [`CPM_IN_COUNT-1:0] pin_raw;
	logic [`CPM_IN_COUNT-1:0] pin_meta;
	logic [`CPM_IN_COUNT-1:0] pin_sync;

	// two-stage synchroniser per pin input
	assign pin_raw = {i_general_io_pin, i_secondary_clock_in_pin, i_data_in_pin,
		i_wclk_pin, i_bclk_pin, i_mclk_pin};

	genvar gi;
	generate
		for (gi = 0; gi < `CPM_IN_COUNT; gi = gi + 1) begin : g_sync
			always_ff @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	// field views
	cpm_pkg::cpm_sel2_t pll_sel;
	cpm_pkg::cpm_sel2_t cdc_sel;
	cpm_pkg::cpm_sel2_t sbclk_sel;
	cpm_pkg::cpm_sel2_t swclk_sel;
	cpm_pkg::cpm_sel2_t adcw_sel;
	cpm_pkg::cpm_sel2_t mic_sel;
	cpm_pkg::cpm_sel2_t din_fn;
	cpm_pkg::cpm_sel2_t sin_fn;
	cpm_pkg::cpm_fn4_t gpio_fn;
	cpm_pkg::cpm_fn3_t dout_fn;
	cpm_pkg::cpm_fn4_t sout_fn;

	assign pll_sel = clk_source_select[`CPM_PLL_SRC_HI:`CPM_PLL_SRC_LO];
	assign cdc_sel = clk_source_select[`CPM_CDC_SRC_HI:`CPM_CDC_SRC_LO];
	assign sbclk_sel = secondary_interface_routing[`CPM_SBCLK_SEL_HI:`CPM_SBCLK_SEL_LO];
	assign swclk_sel = secondary_interface_routing[`CPM_SWCLK_SEL_HI:`CPM_SWCLK_SEL_LO];
	assign adcw_sel = secondary_interface_routing[`CPM_ADCW_SEL_HI:`CPM_ADCW_SEL_LO];
	assign mic_sel = mic_input_select[`CPM_MIC_SEL_HI:`CPM_MIC_SEL_LO];
	assign din_fn = data_in_pin_function[`CPM_PIN2_FN_HI:`CPM_PIN2_FN_LO];
	assign sin_fn = secondary_in_pin_function[`CPM_PIN2_FN_HI:`CPM_PIN2_FN_LO];
	assign gpio_fn = gpio_pin_function[`CPM_GPIO_FN_HI:`CPM_GPIO_FN_LO];
	assign dout_fn = data_out_pin_function[`CPM_DOUT_FN_HI:`CPM_DOUT_FN_LO];
	assign sout_fn = secondary_out_pin_function[`CPM_SOUT_FN_HI:`CPM_SOUT_FN_LO];

	// pin levels that reach internal selectors only when the pin is set as input
	logic gpio_func_in;
	logic din_func_in;
	logic sclk_func_in;
	assign gpio_func_in = (gpio_fn == `CPM_GFN_IN) & pin_sync[`CPM_IN_GPIO];
	assign din_func_in = (din_fn == `CPM_PIN2_FUNC) & pin_sync[`CPM_IN_DIN];
	assign sclk_func_in = (sin_fn == `CPM_PIN2_FUNC) & pin_sync[`CPM_IN_SCLK];

	// register writes
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clk_source_select <= `CPM_RST_ZERO;
			serial_clock_direction <= `CPM_RST_ZERO;
			secondary_interface_routing <= `CPM_RST_ZERO;
			gpio_pin_function <= `CPM_RST_ZERO;
			data_out_pin_function <= `CPM_RST_DOUT_FN;
			data_in_pin_function <= `CPM_RST_DIN_FN;
			secondary_out_pin_function <= `CPM_RST_ZERO;
			secondary_in_pin_function <= `CPM_RST_ZERO;
			headset_detect_control <= `CPM_RST_ZERO;
			mic_input_select <= `CPM_RST_ZERO;
			analog_power_enable <= `CPM_RST_ZERO;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`CPM_ADDR_CLK_SRC: clk_source_select <= i_reg_wdata;
				`CPM_ADDR_SER_DIR: serial_clock_direction <= i_reg_wdata;
				`CPM_ADDR_SEC_ROUTE: secondary_interface_routing <= i_reg_wdata;
				`CPM_ADDR_GPIO_FN: gpio_pin_function <= i_reg_wdata;
				`CPM_ADDR_DOUT_FN: data_out_pin_function <= i_reg_wdata;
				`CPM_ADDR_DIN_FN: data_in_pin_function <= i_reg_wdata;
				`CPM_ADDR_SOUT_FN: secondary_out_pin_function <= i_reg_wdata;
				`CPM_ADDR_SIN_FN: secondary_in_pin_function <= i_reg_wdata;
				`CPM_ADDR_HSD_CTL: headset_detect_control <= i_reg_wdata;
				`CPM_ADDR_MIC_SEL: mic_input_select <= i_reg_wdata;
				`CPM_ADDR_APWR: analog_power_enable <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// register read, general inputs appear in their function registers
	cpm_pkg::cpm_byte_t next_rdata;
	always_comb begin
		next_rdata = `CPM_RST_ZERO;
		case (i_reg_addr)
			`CPM_ADDR_CLK_SRC: next_rdata = clk_source_select;
			`CPM_ADDR_SER_DIR: next_rdata = serial_clock_direction;
			`CPM_ADDR_SEC_ROUTE: next_rdata = secondary_interface_routing;
			`CPM_ADDR_GPIO_FN: begin
				next_rdata = gpio_pin_function;
				next_rdata[`CPM_GPIO_IN_BIT] = (gpio_fn == `CPM_GFN_GPI)
					& pin_sync[`CPM_IN_GPIO];
			end
			`CPM_ADDR_DOUT_FN: next_rdata = data_out_pin_function;
			`CPM_ADDR_DIN_FN: begin
				next_rdata = data_in_pin_function;
				next_rdata[`CPM_PIN_IN_BIT] = (din_fn == `CPM_PIN2_GPI)
					& pin_sync[`CPM_IN_DIN];
			end
			`CPM_ADDR_SOUT_FN: next_rdata = secondary_out_pin_function;
			`CPM_ADDR_SIN_FN: begin
				next_rdata = secondary_in_pin_function;
				next_rdata[`CPM_PIN_IN_BIT] = (sin_fn == `CPM_PIN2_GPI)
					& pin_sync[`CPM_IN_SCLK];
			end
			`CPM_ADDR_HSD_CTL: next_rdata = headset_detect_control;
			`CPM_ADDR_MIC_SEL: next_rdata = mic_input_select;
			`CPM_ADDR_APWR: next_rdata = analog_power_enable;
			default: next_rdata = `CPM_RST_ZERO;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata <= `CPM_RST_ZERO;
			o_analog_power <= `CPM_RST_ZERO;
		end else begin
			o_reg_rdata <= next_rdata;
			o_analog_power <= analog_power_enable;
		end
	end

	// clock source selectors, independent so one pin can feed both
	logic next_pll_ref;
	logic next_codec_clk;
	always_comb begin
		case (pll_sel)
			`CPM_SRC_MCLK: next_pll_ref = pin_sync[`CPM_IN_MCLK];
			`CPM_SRC_BCLK: next_pll_ref = pin_sync[`CPM_IN_BCLK];
			`CPM_SRC_GPIO: next_pll_ref = gpio_func_in;
			default: next_pll_ref = din_func_in;
		endcase
		case (cdc_sel)
			`CPM_SRC_MCLK: next_codec_clk = pin_sync[`CPM_IN_MCLK];
			`CPM_SRC_BCLK: next_codec_clk = pin_sync[`CPM_IN_BCLK];
			`CPM_SRC_GPIO: next_codec_clk = gpio_func_in;
			default: next_codec_clk = 1'b0;
		endcase
	end

	// secondary, adc word clock and mic data selectors
	logic next_sec_bclk;
	logic next_sec_wclk;
	logic next_adc_wclk;
	logic next_sec_din;
	logic next_mic_data;
	always_comb begin
		next_sec_bclk = (sbclk_sel == `CPM_SEC_SCLK) ? sclk_func_in
			: (sbclk_sel == `CPM_SEC_GPIO) ? gpio_func_in : 1'b0;
		next_sec_wclk = (swclk_sel == `CPM_SEC_SCLK) ? sclk_func_in
			: (swclk_sel == `CPM_SEC_GPIO) ? gpio_func_in : 1'b0;
		next_adc_wclk = (adcw_sel == `CPM_SEC_SCLK) ? sclk_func_in
			: (adcw_sel == `CPM_SEC_GPIO) ? gpio_func_in : 1'b0;
		next_sec_din = secondary_interface_routing[`CPM_SDIN_SEL_BIT]
			? sclk_func_in : gpio_func_in;
		case (mic_sel)
			`CPM_MIC_DIN: next_mic_data = din_func_in;
			`CPM_MIC_SCLK: next_mic_data = sclk_func_in;
			`CPM_MIC_GPIO: next_mic_data = gpio_func_in;
			default: next_mic_data = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pll_ref <= 1'b0;
			o_codec_clk <= 1'b0;
			o_sec_bclk_in <= 1'b0;
			o_sec_wclk_in <= 1'b0;
			o_adc_wclk_in <= 1'b0;
			o_sec_din <= 1'b0;
			o_digital_mic_data <= 1'b0;
			o_serial_din <= 1'b0;
			o_headset_detect <= 1'b0;
		end else begin
			o_pll_ref <= next_pll_ref;
			o_codec_clk <= next_codec_clk;
			o_sec_bclk_in <= next_sec_bclk;
			o_sec_wclk_in <= next_sec_wclk;
			o_adc_wclk_in <= next_adc_wclk;
			o_sec_din <= next_sec_din;
			o_digital_mic_data <= next_mic_data;
			o_serial_din <= din_func_in;
			o_headset_detect <= (sin_fn == `CPM_PIN2_HSD)
				& headset_detect_control[`CPM_HSD_EN_BIT]
				& pin_sync[`CPM_IN_SCLK];
		end
	end

	// primary serial clock pins
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bclk_pin <= 1'b0;
			o_bclk_pin_oe <= 1'b0;
			o_bclk_in <= 1'b0;
			o_wclk_pin <= 1'b0;
			o_wclk_pin_oe <= 1'b0;
			o_wclk_in <= 1'b0;
		end else begin
			o_bclk_pin_oe <= serial_clock_direction[`CPM_BCLK_DIR_BIT];
			o_bclk_pin <= i_bclk_core;
			o_bclk_in <= serial_clock_direction[`CPM_BCLK_DIR_BIT]
				? i_bclk_core : pin_sync[`CPM_IN_BCLK];
			o_wclk_pin_oe <= serial_clock_direction[`CPM_WCLK_DIR_BIT];
			o_wclk_pin <= i_wclk_core;
			o_wclk_in <= serial_clock_direction[`CPM_WCLK_DIR_BIT]
				? i_wclk_core : pin_sync[`CPM_IN_WCLK];
		end
	end

	// output pin drivers
	logic next_gpio;
	logic next_gpio_oe;
	logic next_dout;
	logic next_dout_oe;
	logic next_sout;
	logic next_sout_oe;
	always_comb begin
		next_gpio_oe = 1'b1;
		// one code per pin, so gpo and irq1 are exclusive
		case (gpio_fn)
			`CPM_GFN_GPO: next_gpio = gpio_pin_function[`CPM_GPO_VAL_BIT];
			`CPM_GFN_AUX: next_gpio = i_aux_clk;
			`CPM_GFN_IRQ1: next_gpio = i_first_interrupt_out;
			`CPM_GFN_IRQ2: next_gpio = i_second_interrupt_out;
			`CPM_GFN_ADCW: next_gpio = i_adc_wclk;
			`CPM_GFN_SBCLK: next_gpio = i_sec_bclk_out;
			`CPM_GFN_SWCLK: next_gpio = i_sec_wclk_out;
			`CPM_GFN_MCLK: next_gpio = i_digital_mic_clock;
			default: begin
				next_gpio = 1'b0;
				next_gpio_oe = 1'b0;
			end
		endcase
		next_dout_oe = 1'b1;
		case (dout_fn)
			`CPM_DFN_SDOUT: next_dout = i_serial_dout;
			`CPM_DFN_GPO: next_dout = data_out_pin_function[`CPM_GPO_VAL_BIT];
			`CPM_DFN_AUX: next_dout = i_aux_clk;
			`CPM_DFN_IRQ1: next_dout = i_first_interrupt_out;
			`CPM_DFN_IRQ2: next_dout = i_second_interrupt_out;
			`CPM_DFN_SBCLK: next_dout = i_sec_bclk_out;
			`CPM_DFN_SWCLK: next_dout = i_sec_wclk_out;
			default: begin
				next_dout = 1'b0;
				next_dout_oe = 1'b0;
			end
		endcase
		next_sout_oe = 1'b1;
		case (sout_fn)
			`CPM_SFN_GPO: next_sout = secondary_out_pin_function[`CPM_GPO_VAL_BIT];
			`CPM_SFN_AUX: next_sout = i_aux_clk;
			`CPM_SFN_IRQ1: next_sout = i_first_interrupt_out;
			`CPM_SFN_IRQ2: next_sout = i_second_interrupt_out;
			`CPM_SFN_ADCW: next_sout = i_adc_wclk;
			`CPM_SFN_MCLK: next_sout = i_digital_mic_clock;
			`CPM_SFN_SDOUT: next_sout = i_sec_dout;
			`CPM_SFN_SBCLK: next_sout = i_sec_bclk_out;
			`CPM_SFN_SWCLK: next_sout = i_sec_wclk_out;
			default: begin
				next_sout = 1'b0;
				next_sout_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_general_io_pin <= 1'b0;
			o_general_io_pin_oe <= 1'b0;
			o_data_out_pin <= 1'b0;
			o_data_out_pin_oe <= 1'b0;
			o_secondary_data_out_pin <= 1'b0;
			o_secondary_data_out_pin_oe <= 1'b0;
		end else begin
			o_general_io_pin <= next_gpio;
			o_general_io_pin_oe <= next_gpio_oe;
			o_data_out_pin <= next_dout;
			o_data_out_pin_oe <= next_dout_oe;
			o_secondary_data_out_pin <= next_sout;
			o_secondary_data_out_pin_oe <= next_sout_oe;
		end
	end

endmodule : cpm_pin_mux

//--- cpm_map.svh
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// register offsets
`define CPM_ADDR_CLK_SRC 8'h04
`define CPM_ADDR_SER_DIR 8'h1b
`define CPM_ADDR_SEC_ROUTE 8'h1f
`define CPM_ADDR_GPIO_FN 8'h34
`define CPM_ADDR_DOUT_FN 8'h35
`define CPM_ADDR_DIN_FN 8'h36
`define CPM_ADDR_SOUT_FN 8'h37
`define CPM_ADDR_SIN_FN 8'h38
`define CPM_ADDR_HSD_CTL 8'h43
`define CPM_ADDR_MIC_SEL 8'h51
`define CPM_ADDR_APWR 8'h02

// reset values
`define CPM_RST_ZERO 8'h00
`define CPM_RST_DOUT_FN 8'h02
`define CPM_RST_DIN_FN 8'h02

// field positions
`define CPM_PLL_SRC_HI 3
`define CPM_PLL_SRC_LO 2
`define CPM_CDC_SRC_HI 1
`define CPM_CDC_SRC_LO 0
`define CPM_BCLK_DIR_BIT 3
`define CPM_WCLK_DIR_BIT 2
`define CPM_SBCLK_SEL_HI 6
`define CPM_SBCLK_SEL_LO 5
`define CPM_SWCLK_SEL_HI 4
`define CPM_SWCLK_SEL_LO 3
`define CPM_ADCW_SEL_HI 2
`define CPM_ADCW_SEL_LO 1
`define CPM_SDIN_SEL_BIT 0
`define CPM_GPIO_FN_HI 5
`define CPM_GPIO_FN_LO 2
`define CPM_GPIO_IN_BIT 1
`define CPM_GPO_VAL_BIT 0
`define CPM_DOUT_FN_HI 3
`define CPM_DOUT_FN_LO 1
`define CPM_SOUT_FN_HI 4
`define CPM_SOUT_FN_LO 1
`define CPM_PIN2_FN_HI 2
`define CPM_PIN2_FN_LO 1
`define CPM_PIN_IN_BIT 0
`define CPM_HSD_EN_BIT 7
`define CPM_MIC_SEL_HI 5
`define CPM_MIC_SEL_LO 4

// source selector codes
`define CPM_SRC_MCLK 2'h0
`define CPM_SRC_BCLK 2'h1
`define CPM_SRC_GPIO 2'h2
`define CPM_SRC_DIN 2'h3
`define CPM_SEC_GPIO 2'h0
`define CPM_SEC_SCLK 2'h1
`define CPM_MIC_GPIO 2'h0
`define CPM_MIC_SCLK 2'h1
`define CPM_MIC_DIN 2'h2

// two-bit input pin function codes
`define CPM_PIN2_HSD 2'h0
`define CPM_PIN2_FUNC 2'h1
`define CPM_PIN2_GPI 2'h2

// gpio pin function codes
`define CPM_GFN_IN 4'h1
`define CPM_GFN_GPI 4'h2
`define CPM_GFN_GPO 4'h3
`define CPM_GFN_AUX 4'h4
`define CPM_GFN_IRQ1 4'h5
`define CPM_GFN_IRQ2 4'h6
`define CPM_GFN_ADCW 4'h7
`define CPM_GFN_SBCLK 4'h8
`define CPM_GFN_SWCLK 4'h9
`define CPM_GFN_MCLK 4'ha

// data-out pin function codes
`define CPM_DFN_SDOUT 3'h1
`define CPM_DFN_GPO 3'h2
`define CPM_DFN_AUX 3'h3
`define CPM_DFN_IRQ1 3'h4
`define CPM_DFN_IRQ2 3'h5
`define CPM_DFN_SBCLK 3'h6
`define CPM_DFN_SWCLK 3'h7

// secondary-data-out pin function codes
`define CPM_SFN_GPO 4'h2
`define CPM_SFN_AUX 4'h3
`define CPM_SFN_IRQ1 4'h4
`define CPM_SFN_IRQ2 4'h5
`define CPM_SFN_ADCW 4'h6
`define CPM_SFN_MCLK 4'h7
`define CPM_SFN_SDOUT 4'h8
`define CPM_SFN_SBCLK 4'h9
`define CPM_SFN_SWCLK 4'ha

// synchronised input vector positions
`define CPM_IN_MCLK 0
`define CPM_IN_BCLK 1
`define CPM_IN_WCLK 2
`define CPM_IN_DIN 3
`define CPM_IN_SCLK 4
`define CPM_IN_GPIO 5
`define CPM_IN_COUNT 6

`endif

//--- cpm_pkg.sv
package cpm_pkg;
	typedef logic [7:0] cpm_byte_t;
	typedef logic [1:0] cpm_sel2_t;
	typedef logic [2:0] cpm_fn3_t;
	typedef logic [3:0] cpm_fn4_t;
endpackage : cpm_pkg

//--- cpm_pin_peer.sv
`timescale 1ns/1ns

// pin-side peripherals: each two-way pin shows the device level while the device drives it
module cpm_pin_peer (
	input wire logic [5:0] i_lvl,
	input wire logic i_bclk_drv,
	input wire logic i_bclk_oe,
	input wire logic i_wclk_drv,
	input wire logic i_wclk_oe,
	input wire logic i_gpio_drv,
	input wire logic i_gpio_oe,
	output logic [5:0] o_wire
);
	always_comb begin
		o_wire = i_lvl;
		if (i_bclk_oe) begin
			o_wire[1] = i_bclk_drv;
		end
		if (i_wclk_oe) begin
			o_wire[2] = i_wclk_drv;
		end
		if (i_gpio_oe) begin
			o_wire[5] = i_gpio_drv;
		end
	end
endmodule : cpm_pin_peer

//--- cpm_pin_mux_chk.sv
`timescale 1ns/1ns

module cpm_pin_mux_chk (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_mclk_pin,
	input wire logic i_bclk_pin,
	input wire logic i_data_in_pin,
	input wire logic i_secondary_clock_in_pin,
	input wire logic i_general_io_pin,
	input wire logic i_bclk_core,
	input wire logic i_sec_dout,
	input wire logic o_bclk_pin,
	input wire logic o_bclk_pin_oe,
	input wire logic o_data_out_pin_oe,
	input wire logic o_secondary_data_out_pin,
	input wire logic o_secondary_data_out_pin_oe,
	input wire logic o_general_io_pin,
	input wire logic o_general_io_pin_oe,
	input wire logic o_pll_ref,
	input wire logic o_sec_din,
	input wire logic o_digital_mic_data,
	input wire logic o_headset_detect
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_bclk_drive_value: assert property (o_bclk_pin_oe |-> o_bclk_pin == $past(i_bclk_core))
		else $error("bit clock pin not following core clock");
	a_dout_boot_drive: assert property ($rose(i_rst_b) |=> o_data_out_pin_oe)
		else $error("data-out pin not driven after reset");
	a_dout_fn_off: assert property ((i_reg_wr && i_reg_addr == 8'h35 && i_reg_wdata[3:1] == 3'h0)
		|-> ##2 !o_data_out_pin_oe) else $error("data-out pin driven with code 000");
	a_gpio_gpo_value: assert property ((i_reg_wr && i_reg_addr == 8'h34 && i_reg_wdata[5:2] == 4'h3)
		|-> ##2 (o_general_io_pin_oe && o_general_io_pin == $past(i_reg_wdata[0], 2)))
		else $error("gpio general output wrong");
	a_sout_sec_data: assert property ((i_reg_wr && i_reg_addr == 8'h37 && i_reg_wdata[4:1] == 4'h8)
		|-> ##2 (o_secondary_data_out_pin_oe && o_secondary_data_out_pin == $past(i_sec_dout)))
		else $error("secondary data out not on pin");
	a_clk_src_readback: assert property ((i_reg_wr && i_reg_addr == 8'h04) ##1 (i_reg_addr == 8'h04)
		|=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("clock source readback wrong");
	a_unmapped_zero: assert property (i_reg_addr == 8'h03 |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_headset_level: assert property (o_headset_detect |-> $past(i_secondary_clock_in_pin, 3))
		else $error("headset detect without pin level");
	a_pll_ref_src: assert property (o_pll_ref |-> ($past(i_mclk_pin, 3) || $past(i_bclk_pin, 3)
		|| $past(i_general_io_pin, 3) || $past(i_data_in_pin, 3))) else $error("pll ref from nowhere");
	a_mic_data_src: assert property (o_digital_mic_data |-> ($past(i_data_in_pin, 3)
		|| $past(i_secondary_clock_in_pin, 3) || $past(i_general_io_pin, 3)))
		else $error("mic data from nowhere");
	a_sec_din_src: assert property (o_sec_din |-> ($past(i_secondary_clock_in_pin, 3)
		|| $past(i_general_io_pin, 3))) else $error("secondary data in from nowhere");
endmodule : cpm_pin_mux_chk

bind cpm_pin_mux cpm_pin_mux_chk cpm_pin_mux_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .i_mclk_pin(i_mclk_pin), .i_bclk_pin(i_bclk_pin),
	.i_data_in_pin(i_data_in_pin), .i_secondary_clock_in_pin(i_secondary_clock_in_pin),
	.i_general_io_pin(i_general_io_pin), .i_bclk_core(i_bclk_core), .i_sec_dout(i_sec_dout),
	.o_bclk_pin(o_bclk_pin), .o_bclk_pin_oe(o_bclk_pin_oe), .o_data_out_pin_oe(o_data_out_pin_oe),
	.o_secondary_data_out_pin(o_secondary_data_out_pin),
	.o_secondary_data_out_pin_oe(o_secondary_data_out_pin_oe),
	.o_general_io_pin(o_general_io_pin), .o_general_io_pin_oe(o_general_io_pin_oe),
	.o_pll_ref(o_pll_ref), .o_sec_din(o_sec_din), .o_digital_mic_data(o_digital_mic_data),
	.o_headset_detect(o_headset_detect));

//--- tb.sv
`timescale 1ns/1ns

module tb;
	typedef struct {logic [7:0] a; logic [7:0] d; int s; int p;} cpm_orow_t;
	typedef struct {logic [7:0] a1; logic [7:0] d1; logic [7:0] a2; logic [7:0] d2; int p; int o;} cpm_irow_t;
	logic clk, rst_b, wr, bcore, wcore, bclk_o, bclk_oe, wclk_o, wclk_oe;
	logic [7:0] addr, wdata, rdata, apwr;
	logic [5:0] lvl;
	wire [5:0] pw;
	logic [9:0] src;
	logic [2:0] po, poe;
	logic [10:0] core;
	int num_errors = 0;
	int compares = 0;
	// address, write value, source index (0 = register bit), pin 0 dout 1 sec-out 2 gpio
	cpm_orow_t orows [24] = '{'{8'h34, 8'h0c, 0, 2}, '{8'h34, 8'h10, 2, 2}, '{8'h34, 8'h14, 3, 2},
		'{8'h34, 8'h18, 4, 2}, '{8'h34, 8'h1c, 5, 2}, '{8'h34, 8'h20, 6, 2}, '{8'h34, 8'h24, 7, 2},
		'{8'h34, 8'h28, 8, 2}, '{8'h35, 8'h02, 1, 0}, '{8'h35, 8'h04, 0, 0}, '{8'h35, 8'h06, 2, 0},
		'{8'h35, 8'h08, 3, 0}, '{8'h35, 8'h0a, 4, 0}, '{8'h35, 8'h0c, 6, 0}, '{8'h35, 8'h0e, 7, 0},
		'{8'h37, 8'h04, 0, 1}, '{8'h37, 8'h06, 2, 1}, '{8'h37, 8'h08, 3, 1}, '{8'h37, 8'h0a, 4, 1},
		'{8'h37, 8'h0c, 5, 1}, '{8'h37, 8'h0e, 8, 1}, '{8'h37, 8'h10, 9, 1}, '{8'h37, 8'h12, 6, 1},
		'{8'h37, 8'h14, 7, 1}};
	// pin function write, selector write, pin index, routed output index
	cpm_irow_t irows [21] = '{'{8'h04, 8'h00, 8'h04, 8'h00, 0, 0}, '{8'h04, 8'h04, 8'h04, 8'h04, 1, 0},
		'{8'h34, 8'h04, 8'h04, 8'h08, 5, 0}, '{8'h36, 8'h02, 8'h04, 8'h0c, 3, 0},
		'{8'h04, 8'h00, 8'h04, 8'h00, 0, 1}, '{8'h04, 8'h01, 8'h04, 8'h01, 1, 1},
		'{8'h34, 8'h04, 8'h04, 8'h02, 5, 1}, '{8'h1b, 8'h00, 8'h1b, 8'h00, 1, 2},
		'{8'h1b, 8'h00, 8'h1b, 8'h00, 2, 3}, '{8'h36, 8'h02, 8'h36, 8'h02, 3, 4},
		'{8'h38, 8'h02, 8'h1f, 8'h20, 4, 5}, '{8'h34, 8'h04, 8'h1f, 8'h00, 5, 5},
		'{8'h38, 8'h02, 8'h1f, 8'h08, 4, 6}, '{8'h34, 8'h04, 8'h1f, 8'h00, 5, 6},
		'{8'h38, 8'h02, 8'h1f, 8'h02, 4, 7}, '{8'h34, 8'h04, 8'h1f, 8'h00, 5, 7},
		'{8'h38, 8'h02, 8'h1f, 8'h01, 4, 8}, '{8'h34, 8'h04, 8'h1f, 8'h00, 5, 8},
		'{8'h36, 8'h02, 8'h51, 8'h20, 3, 9}, '{8'h38, 8'h02, 8'h51, 8'h10, 4, 9},
		'{8'h34, 8'h04, 8'h51, 8'h00, 5, 9}};
	logic [15:0] rv [12] = '{16'h0400, 16'h1b00, 16'h1f00, 16'h3400, 16'h3502, 16'h3602,
		16'h3700, 16'h3800, 16'h4300, 16'h5100, 16'h0200, 16'h0300};

	cpm_pin_mux cpm_pin_mux_inst (.i_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_mclk_pin(pw[0]), .i_bclk_pin(pw[1]),
		.o_bclk_pin(bclk_o), .o_bclk_pin_oe(bclk_oe), .i_wclk_pin(pw[2]), .o_wclk_pin(wclk_o),
		.o_wclk_pin_oe(wclk_oe), .i_data_in_pin(pw[3]), .o_data_out_pin(po[0]),
		.o_data_out_pin_oe(poe[0]), .i_secondary_clock_in_pin(pw[4]),
		.o_secondary_data_out_pin(po[1]), .o_secondary_data_out_pin_oe(poe[1]),
		.i_general_io_pin(pw[5]), .o_general_io_pin(po[2]), .o_general_io_pin_oe(poe[2]),
		.i_bclk_core(bcore), .i_wclk_core(wcore), .i_serial_dout(src[1]), .i_aux_clk(src[2]),
		.i_first_interrupt_out(src[3]), .i_second_interrupt_out(src[4]), .i_adc_wclk(src[5]),
		.i_sec_bclk_out(src[6]), .i_sec_wclk_out(src[7]), .i_sec_dout(src[9]),
		.i_digital_mic_clock(src[8]), .o_pll_ref(core[0]), .o_codec_clk(core[1]),
		.o_bclk_in(core[2]), .o_wclk_in(core[3]), .o_serial_din(core[4]),
		.o_sec_bclk_in(core[5]), .o_sec_wclk_in(core[6]), .o_adc_wclk_in(core[7]),
		.o_sec_din(core[8]), .o_digital_mic_data(core[9]), .o_headset_detect(core[10]),
		.o_analog_power(apwr));

	cpm_pin_peer cpm_pin_peer_inst (.i_lvl(lvl), .i_bclk_drv(bclk_o), .i_bclk_oe(bclk_oe),
		.i_wclk_drv(wclk_o), .i_wclk_oe(wclk_oe), .i_gpio_drv(po[2]), .i_gpio_oe(poe[2]),
		.o_wire(pw));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		// idle edge so a following write never re-raises the strobe in the same step
		step(1);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		step(1);
		chk("rdata", rdata, exp);
	endtask : rreg

	task automatic rst_vals;
		foreach (rv[i]) rreg(rv[i][15:8], rv[i][7:0]);
	endtask : rst_vals

	task automatic stop_test;
		$display("num_errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	initial begin
		{wr, bcore, wcore, rst_b} = 4'h0;
		addr = 8'h00;
		wdata = 8'h00;
		lvl = 6'h00;
		src = 10'h000;
		repeat (16) @(posedge clk);
		#1;
		chk("dout_oe_rst", poe[0], 1'b0);
		rst_b = 1'b1;
		step(2);
		chk("dout_oe", poe[0], 1'b1);
		chk("apwr", apwr, 8'h00);
		rst_vals();
		foreach (orows[i]) begin
			for (int v = 0; v < 2; v++) begin
				wreg(orows[i].a, orows[i].d | ((orows[i].s == 0) ? 8'(v) : 8'h00));
				src = v ? (10'h001 << orows[i].s) : ~(10'h001 << orows[i].s);
				step(2);
				chk("pin", po[orows[i].p], v[0]);
				chk("pin_oe", poe[orows[i].p], 1'b1);
			end
		end
		foreach (irows[i]) begin
			wreg(irows[i].a1, irows[i].d1);
			wreg(irows[i].a2, irows[i].d2);
			for (int v = 0; v < 2; v++) begin
				lvl = v ? (6'h01 << irows[i].p) : ~(6'h01 << irows[i].p);
				step(4);
				chk("core_in", core[irows[i].o], v[0]);
			end
		end
		// driven serial clocks, then back to inputs
		wreg(8'h1b, 8'h0c);
		bcore = 1'b1;
		step(2);
		chk("bclk_oe", {bclk_oe, wclk_oe, bclk_o, wclk_o}, 8'h0e);
		{bcore, wcore} = 2'h1;
		step(1);
		chk("clk_pins", {bclk_o, wclk_o}, 8'h01);
		chk("clk_loop", core[3:2], 8'h02);
		wreg(8'h1b, 8'h00);
		step(1);
		chk("clk_oe_off", {bclk_oe, wclk_oe}, 8'h00);
		// one pin feeding both clock trees
		wreg(8'h04, 8'h05);
		lvl = 6'h02;
		step(4);
		chk("pll_codec", core[1:0], 8'h03);
		// gpio selected but pin not set as input
		wreg(8'h34, 8'h00);
		wreg(8'h04, 8'h08);
		lvl = 6'h20;
		step(4);
		chk("pll_refused", core[0], 1'b0);
		wreg(8'h38, 8'h00);
		wreg(8'h43, 8'h80);
		lvl = 6'h10;
		step(4);
		chk("hsd_on", core[10], 1'b1);
		wreg(8'h43, 8'h00);
		step(4);
		chk("hsd_off", core[10], 1'b0);
		wreg(8'h34, 8'h08);
		wreg(8'h36, 8'h04);
		wreg(8'h38, 8'h04);
		lvl = 6'h38;
		step(4);
		rreg(8'h34, 8'h0a);
		rreg(8'h36, 8'h05);
		rreg(8'h38, 8'h05);
		wreg(8'h35, 8'h00);
		step(1);
		chk("dout_off", poe[0], 1'b0);
		wreg(8'h02, 8'ha5);
		step(1);
		chk("apwr_on", apwr, 8'ha5);
		wreg(8'h03, 8'hff);
		rreg(8'h03, 8'h00);
		lvl = 6'h00;
		rst_b = 1'b0;
		step(2);
		rst_b = 1'b1;
		step(2);
		rst_vals();
		stop_test();
	end
endmodule : tb
